// ---- inc/tcsm_defines.vh ----
// Purpose: constants for the threshold capture and stop monitor
// Assumes: 50 MHz system clock, APB register access
// Notes:   offsets are byte addresses of 32-bit words
`ifndef TCSM_DEFINES_VH
`define TCSM_DEFINES_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TCSM_CLK_HZ 50000000
`define TCSM_SAMPLE_US 2000
`define TCSM_SAMPLE_CYC ((`TCSM_CLK_HZ / 1000000) * `TCSM_SAMPLE_US)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TCSM_REG_CTRL 12'h000
`define TCSM_REG_CAP_THR 12'h004
`define TCSM_REG_FACTOR 12'h008
`define TCSM_REG_OFFSET 12'h00C
`define TCSM_REG_STOP_THR 12'h010
`define TCSM_REG_RESULT 12'h014
`define TCSM_REG_STATUS 12'h018

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define TCSM_CTRL_CAP_ARM 0
`define TCSM_CTRL_STOP_ARM 1
`define TCSM_CTRL_CAP_TRG_LO 2
`define TCSM_CTRL_CAP_TRG_HI 3
`define TCSM_CTRL_CAP_LESS 4
`define TCSM_CTRL_CAP_MEAS_LO 5
`define TCSM_CTRL_CAP_MEAS_HI 6
`define TCSM_CTRL_STOP_SRC_LO 7
`define TCSM_CTRL_STOP_SRC_HI 8
`define TCSM_CTRL_STOP_LESS 9
`define TCSM_CTRL_FAC_VAR 10
`define TCSM_CTRL_OFS_VAR 11
`define TCSM_CTRL_THR_VAR 12

// ----------------------------------------------------------------
// source codes and reset values
// ----------------------------------------------------------------
`define TCSM_SRC_POS 2'h0
`define TCSM_SRC_FORCE 2'h1
`define TCSM_SRC_MEAS 2'h2
`define TCSM_FACTOR_ONE 32'h00010000
`define TCSM_CTRL_RST 32'h00000020
`define TCSM_FRAC_BITS 16

`endif

// ---- src/tcsm_monitor.v ----
// Purpose: threshold capture and stop monitor for a press axis
// Assumes: sensor inputs synchronous to clk_i, APB slave access
// Notes:   arms are cleared when the positioning move ends
//
// Behaviour
// - evaluate comparisons once per 2 ms tick
// - signals seen only at sample instants
// - capture measured signal when trigger condition holds
// - result is captured value times factor plus offset
// - factor resets to one, offset to zero
// - factor and offset from constant or variable
// - trigger select: position, force, measuring sensor
// - greater compare holds when trigger >= threshold
// - smaller compare holds when trigger <= threshold
// - measured select: position, force, measuring sensor
// - capture defaults: position, greater, zero, force
// - stop asserted at first crossing sample
// - greater stop when signal rises above threshold
// - smaller stop when signal drops below threshold
// - stop threshold from constant or variable
// - stop defaults: position, greater, zero, constant
// - arms last one move, cleared at move end
`timescale 1ns/10ps
`include "tcsm_defines.vh"

module tcsm_monitor #(
    parameter WIDTH = 32,
    parameter SAMPLE_CYC = `TCSM_SAMPLE_CYC
) (
    input wire clk_i, // system clock 50 MHz
    input wire rst_i, // synchronous reset, active high
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output wire [31:0] prdata, // apb read data
    output wire pready, // apb ready
    output wire pslverr, // apb error on unmapped address
    input wire [WIDTH-1:0] axis_pos_i, // axis position sample
    input wire [WIDTH-1:0] force_i, // force sensor sample
    input wire [WIDTH-1:0] meas_i, // measuring sensor sample
    input wire [31:0] var_factor_i, // user variable factor, Q16.16
    input wire [WIDTH-1:0] var_offset_i, // user variable offset
    input wire [WIDTH-1:0] var_thr_i, // user variable stop threshold
    input wire move_active_i, // high while a positioning move runs
    output wire [WIDTH-1:0] result_o, // scaled capture result
    output wire cap_done_o, // one-cycle pulse when result written
    output wire axis_stop_o, // axis stop command
    output wire sample_tick_o // sample instant pulse
);

    // ----------------------------------------------------------------
    // state declarations
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_MOVE = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;

    reg [31:0] ctrl_ff;
    reg [WIDTH-1:0] cap_thr_ff;
    reg [31:0] factor_ff;
    reg [WIDTH-1:0] offset_ff;
    reg [WIDTH-1:0] stop_thr_ff;
    reg [WIDTH-1:0] result_ff;
    reg [WIDTH-1:0] raw_ff;
    reg cap_armed_ff;
    reg stop_armed_ff;
    reg captured_ff;
    reg scale_pend_ff;
    reg done_ff;
    reg stop_ff;
    reg [31:0] prdata_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [31:0] rd_data;
    reg rd_hit;

    wire tick;
    wire [WIDTH-1:0] scaled;
    wire apb_wr;
    wire arm_cap_wr;
    wire arm_stop_wr;
    wire [1:0] cap_trg_sel;
    wire [1:0] cap_meas_sel;
    wire [1:0] stop_src_sel;
    wire signed [WIDTH-1:0] trg_val;
    wire signed [WIDTH-1:0] meas_val;
    wire signed [WIDTH-1:0] mon_val;
    wire signed [WIDTH-1:0] cap_thr_s;
    wire signed [WIDTH-1:0] stop_thr_s;
    wire [31:0] factor_sel;
    wire [WIDTH-1:0] offset_sel;
    wire cap_hit;
    wire stop_beyond;
    wire move_end;

    // ----------------------------------------------------------------
    // sample tick and scaling
    // ----------------------------------------------------------------
    tcsm_tick_gen #(
        .PERIOD(SAMPLE_CYC)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // factor and offset come from constant register or user variable
    assign factor_sel = ctrl_ff[`TCSM_CTRL_FAC_VAR] ? var_factor_i : factor_ff;
    assign offset_sel = ctrl_ff[`TCSM_CTRL_OFS_VAR] ? var_offset_i : offset_ff;

    tcsm_scale #(
        .WIDTH(WIDTH)
    ) u_scale (
        .value_i(raw_ff),
        .factor_i(factor_sel),
        .offset_i(offset_sel),
        .result_o(scaled)
    );

    // ----------------------------------------------------------------
    // source selection and comparison
    // ----------------------------------------------------------------
    assign cap_trg_sel = ctrl_ff[`TCSM_CTRL_CAP_TRG_HI:`TCSM_CTRL_CAP_TRG_LO];
    assign cap_meas_sel = ctrl_ff[`TCSM_CTRL_CAP_MEAS_HI:`TCSM_CTRL_CAP_MEAS_LO];
    assign stop_src_sel = ctrl_ff[`TCSM_CTRL_STOP_SRC_HI:`TCSM_CTRL_STOP_SRC_LO];

    // three-way signal selectors
    assign trg_val = (cap_trg_sel == `TCSM_SRC_FORCE) ? force_i :
                     (cap_trg_sel == `TCSM_SRC_MEAS) ? meas_i : axis_pos_i;
    assign meas_val = (cap_meas_sel == `TCSM_SRC_POS) ? axis_pos_i :
                      (cap_meas_sel == `TCSM_SRC_MEAS) ? meas_i : force_i;
    assign mon_val = (stop_src_sel == `TCSM_SRC_FORCE) ? force_i :
                     (stop_src_sel == `TCSM_SRC_MEAS) ? meas_i : axis_pos_i;

    assign cap_thr_s = cap_thr_ff;
    assign stop_thr_s = ctrl_ff[`TCSM_CTRL_THR_VAR] ? var_thr_i : stop_thr_ff;

    // capture condition is inclusive of the threshold
    assign cap_hit = ctrl_ff[`TCSM_CTRL_CAP_LESS] ? (trg_val <= cap_thr_s) :
                     (trg_val >= cap_thr_s);
    // stop condition is a strict excursion past the threshold
    assign stop_beyond = ctrl_ff[`TCSM_CTRL_STOP_LESS] ? (mon_val < stop_thr_s) :
                         (mon_val > stop_thr_s);

    // ----------------------------------------------------------------
    // move tracking state machine
    // ----------------------------------------------------------------
    assign move_end = (state_ff == ST_MOVE) && !move_active_i;

    // idle until a move starts, done for one cycle when it ends
    always @* begin
        case (state_ff)
            ST_IDLE: begin
                nxt_state = move_active_i ? ST_MOVE : ST_IDLE;
            end
            ST_MOVE: begin
                nxt_state = move_active_i ? ST_MOVE : ST_DONE;
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // apb register access
    // ----------------------------------------------------------------
    assign apb_wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign arm_cap_wr = apb_wr && (paddr == `TCSM_REG_CTRL) && pwdata[`TCSM_CTRL_CAP_ARM];
    assign arm_stop_wr = apb_wr && (paddr == `TCSM_REG_CTRL) && pwdata[`TCSM_CTRL_STOP_ARM];

    // read mux with decode hit flag
    always @* begin
        rd_hit = 1'b1;
        rd_data = 32'h00000000;
        case (paddr)
            `TCSM_REG_CTRL: rd_data = {ctrl_ff[31:2], stop_armed_ff, cap_armed_ff};
            `TCSM_REG_CAP_THR: rd_data = cap_thr_ff;
            `TCSM_REG_FACTOR: rd_data = factor_ff;
            `TCSM_REG_OFFSET: rd_data = offset_ff;
            `TCSM_REG_STOP_THR: rd_data = stop_thr_ff;
            `TCSM_REG_RESULT: rd_data = result_ff;
            `TCSM_REG_STATUS: rd_data = {28'h0000000, stop_ff, captured_ff, stop_armed_ff, cap_armed_ff};
            default: rd_hit = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !rd_hit;

    // ----------------------------------------------------------------
    // read data register
    // ----------------------------------------------------------------
    // read word latched at the end of the setup cycle, shown through the
    // access cycle and cleared after it, so idle cycles read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            prdata_ff <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= rd_data;
        end else begin
            prdata_ff <= 32'h00000000;
        end
    end

    // configuration registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `TCSM_CTRL_RST;
            cap_thr_ff <= {WIDTH{1'b0}};
            factor_ff <= `TCSM_FACTOR_ONE;
            offset_ff <= {WIDTH{1'b0}};
            stop_thr_ff <= {WIDTH{1'b0}};
        end else if (apb_wr) begin
            // unmapped and read-only offsets leave the configuration untouched
            case (paddr)
                `TCSM_REG_CTRL: ctrl_ff <= {19'h0, pwdata[12:2], 2'h0};
                `TCSM_REG_CAP_THR: cap_thr_ff <= pwdata[WIDTH-1:0];
                `TCSM_REG_FACTOR: factor_ff <= pwdata;
                `TCSM_REG_OFFSET: offset_ff <= pwdata[WIDTH-1:0];
                `TCSM_REG_STOP_THR: stop_thr_ff <= pwdata[WIDTH-1:0];
                default: ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // arming, capture and stop
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            cap_armed_ff <= 1'b0;
            stop_armed_ff <= 1'b0;
            captured_ff <= 1'b0;
            scale_pend_ff <= 1'b0;
            raw_ff <= {WIDTH{1'b0}};
            result_ff <= {WIDTH{1'b0}};
            done_ff <= 1'b0;
            stop_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            // arming write wins over the move-end disarm
            if (arm_cap_wr) begin
                cap_armed_ff <= 1'b1;
                captured_ff <= 1'b0;
            end else if (move_end) begin
                cap_armed_ff <= 1'b0;
            end
            if (arm_stop_wr) begin
                stop_armed_ff <= 1'b1;
                stop_ff <= 1'b0;
            end else if (move_end) begin
                stop_armed_ff <= 1'b0;
                stop_ff <= 1'b0;
            end
            // capture latches once per armed move, only on a tick
            if (tick && cap_armed_ff && !captured_ff && move_active_i && cap_hit) begin
                raw_ff <= meas_val;
                captured_ff <= 1'b1;
                scale_pend_ff <= 1'b1;
            end
            // result written the cycle after capture, with done pulse
            if (scale_pend_ff) begin
                result_ff <= scaled;
                done_ff <= 1'b1;
                scale_pend_ff <= 1'b0;
            end
            // stop on the first sample past the threshold
            // placed last so a crossing in an arm-write cycle still sets the stop if the stop was already armed
            if (tick && stop_armed_ff && move_active_i) begin
                if (stop_beyond) begin
                    stop_ff <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata = prdata_ff;
    assign result_o = result_ff;
    assign cap_done_o = done_ff;
    assign axis_stop_o = stop_ff;
    assign sample_tick_o = tick;

endmodule // tcsm_monitor

// ---- src/tcsm_scale.v ----
// Purpose: fixed-point scale and offset of a captured value
// Assumes: factor in signed Q16.16, value and offset plain signed
// Notes:   combinational; result truncated to WIDTH bits
`timescale 1ns/10ps
`include "tcsm_defines.vh"

module tcsm_scale #(
    parameter WIDTH = 32
) (
    input wire signed [WIDTH-1:0] value_i, // raw captured value
    input wire signed [31:0] factor_i, // Q16.16 factor
    input wire signed [WIDTH-1:0] offset_i, // additive offset
    output wire signed [WIDTH-1:0] result_o // value * factor + offset
);

    wire signed [WIDTH+31:0] prod;
    wire signed [WIDTH+31:0] shifted;

    // ----------------------------------------------------------------
    // multiply, drop fraction bits, add offset
    // ----------------------------------------------------------------
    assign prod = value_i * factor_i;
    assign shifted = prod >>> `TCSM_FRAC_BITS;
    assign result_o = shifted[WIDTH-1:0] + offset_i;

endmodule // tcsm_scale

// ---- src/tcsm_tick_gen.v ----
// Purpose: periodic sample tick generator
// Assumes: one system clock, synchronous reset
// Notes:   tick is one clock wide, once every PERIOD clocks
`timescale 1ns/10ps
`include "tcsm_defines.vh"

module tcsm_tick_gen #(
    parameter PERIOD = `TCSM_SAMPLE_CYC
) (
    input wire clk_i, // system clock
    input wire rst_i, // synchronous reset, active high
    output wire tick_o // one-cycle sample pulse
);

    reg [31:0] cnt_ff;
    wire [31:0] nxt_cnt;

    // ----------------------------------------------------------------
    // period counter
    // ----------------------------------------------------------------
    assign nxt_cnt = (cnt_ff == PERIOD - 1) ? 32'h00000000 : cnt_ff + 32'h00000001;
    assign tick_o = (cnt_ff == PERIOD - 1);

    // count clocks and wrap at the period
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 32'h00000000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule // tcsm_tick_gen

// ---- tb/tcsm_axis_model.sv ----
// Purpose: press axis drive and sensor model
// Assumes: sample tick paces the ramp
// Notes:   position ramps by four per tick, freezes on stop
`timescale 1ns/10ps
module tcsm_axis_model (
    input wire clk_i, // system clock
    input wire rst_i, // synchronous reset
    input wire tick_i, // sample tick
    input wire stop_i, // axis stop command
    input wire run_i, // move request
    input wire spike_i, // short force glitch
    output reg signed [31:0] pos_o, // axis position
    output wire signed [31:0] force_o, // force sensor
    output wire signed [31:0] meas_o, // measuring sensor
    output reg move_o // move running
);
// position ramps while moving, halts on a stop command
always @(posedge clk_i) begin
    move_o <= run_i;
    if (rst_i || !run_i)
        pos_o <= 32'sh0;
    else if (tick_i && !stop_i)
        pos_o <= pos_o + 32'sh4;
end
// sensors follow the position
assign force_o = spike_i ? 32'sh7FFF0000 : pos_o * 32'sh3;
assign meas_o = 32'sh1F4 - pos_o;
endmodule // tcsm_axis_model

// ---- tb/tcsm_checker.sv ----
// Purpose: port-level checks for the capture and stop monitor
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to the monitor from the bench top file
`timescale 1ns/10ps
module tcsm_checker #(
    parameter WIDTH = 32,
    parameter SAMPLE_CYC = 100000
) (
    input wire clk_i, // system clock
    input wire rst_i, // synchronous reset
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb write
    input wire move_active_i, // move running
    input wire [WIDTH-1:0] result_o, // scaled result
    input wire cap_done_o, // capture done pulse
    input wire axis_stop_o, // axis stop command
    input wire sample_tick_o // sample tick
);
// ----------------------------------------------------------------
// helper
// ----------------------------------------------------------------
// cycles since the last sample tick
reg [31:0] cnt_ff;
always @(posedge clk_i) begin
    if (rst_i || sample_tick_o)
        cnt_ff <= 32'h0;
    else
        cnt_ff <= cnt_ff + 32'h1;
end
// ----------------------------------------------------------------
// properties
// ----------------------------------------------------------------
default clocking cb @(posedge clk_i);
endclocking
default disable iff (rst_i);
AST_TICK_PERIOD: assert property (sample_tick_o == (cnt_ff == SAMPLE_CYC - 1))
    else $error("sample tick off period");
AST_DONE_PULSE: assert property (cap_done_o |=> !cap_done_o)
    else $error("done pulse too long");
AST_RESULT_HOLD: assert property (!cap_done_o |-> $stable(result_o))
    else $error("result moved without done");
AST_DONE_TICK: assert property ($rose(cap_done_o) |-> $past(sample_tick_o, 2))
    else $error("capture not tied to a tick");
AST_DONE_MOVE: assert property (cap_done_o |-> $past(move_active_i, 2))
    else $error("capture outside a move");
AST_STOP_TICK: assert property ($rose(axis_stop_o) |-> $past(sample_tick_o))
    else $error("stop between samples");
AST_STOP_MOVE: assert property ($rose(axis_stop_o) |-> $past(move_active_i))
    else $error("stop outside a move");
AST_STOP_END: assert property ($fell(move_active_i) |-> ##[1:2] !axis_stop_o)
    else $error("stop kept after move end");
AST_STOP_HOLD: assert property (axis_stop_o && move_active_i && !(psel && penable && pwrite) |=> axis_stop_o)
    else $error("stop dropped in move");
endmodule // tcsm_checker

// ---- tb/threshold_capture_and_stop_monitor_tb_top.sv ----
// Purpose: self-checking bench for the capture and stop monitor
// Assumes: short sample period, axis model on the sensor side
// Notes:   expected captures are rebuilt from sensor values at each tick
`timescale 1ns/10ps
module threshold_capture_and_stop_monitor_tb_top;
localparam SC = 20;
reg clk_i = 1'b0;
reg rst_i = 1'b1;
reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, spike = 1'b0, glitch = 1'b0, err;
reg arm_c = 1'b0, got = 1'b0, less = 1'b0;
reg [1:0] tsel = 2'h0, msel = 2'h0;
reg [7:0] since = 8'h0;
reg [11:0] paddr = 12'h0;
reg [31:0] pwdata = 32'h0, vfac = 32'h0, vofs = 32'h0, vthr = 32'h0, fac = 32'h10000, ofs = 32'h0, rd, last = 32'h0;
reg signed [31:0] thr = 32'h0, raw = 32'h0;
wire [31:0] prdata, result_o;
wire signed [31:0] pos, frc, mea;
wire pready, pslverr, cap_done_o, axis_stop_o, sample_tick_o, mv;
integer bad_count = 0, compares = 0, ncap = 0, i;
tcsm_monitor #(.WIDTH(32), .SAMPLE_CYC(SC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .axis_pos_i(pos), .force_i(frc), .meas_i(mea), .var_factor_i(vfac), .var_offset_i(vofs), .var_thr_i(vthr),
    .move_active_i(mv), .result_o(result_o), .cap_done_o(cap_done_o), .axis_stop_o(axis_stop_o),
    .sample_tick_o(sample_tick_o));
tcsm_axis_model u_axis (.clk_i(clk_i), .rst_i(rst_i), .tick_i(sample_tick_o), .stop_i(axis_stop_o),
    .run_i(run), .spike_i(spike), .pos_o(pos), .force_o(frc), .meas_o(mea), .move_o(mv));
// 50 MHz clock
initial forever #10 clk_i = ~clk_i;
function signed [31:0] sel(input [1:0] s);
    begin
        sel = (s == 2'h0) ? pos : (s == 2'h1) ? frc : mea;
    end
endfunction
// tick-time reference of the capture, glitches placed between ticks
always @(posedge clk_i) begin
    since <= sample_tick_o ? 8'h0 : since + 8'h1;
    spike <= glitch && since > 8'h3 && since < 8'h8;
    if (cap_done_o === 1'b1)
        ncap <= ncap + 1;
    if (sample_tick_o === 1'b1 && mv && arm_c && !got && (less ? sel(tsel) <= thr : sel(tsel) >= thr)) begin
        got <= 1'b1;
        raw <= sel(msel);
    end
end
task end_sim;
    begin
        if (bad_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
endtask
task chk(input [31:0] seen, input [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    end
endtask
// one apb transfer, waits for ready
task apb(input w, input [11:0] a, input [31:0] d);
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1)
            @(posedge clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    end
endtask
// arm, run one six-tick move, judge count and result
task cap_run(input [31:0] ctrl, input [31:0] t, input ok);
    integer n;
    reg signed [63:0] p;
    begin
        thr = t;
        tsel = ctrl[3:2];
        less = ctrl[4];
        msel = ctrl[6:5];
        got = 1'b0;
        arm_c = ctrl[0];
        n = ncap;
        apb(1'b1, 12'h004, t);
        apb(1'b1, 12'h000, ctrl);
        run <= 1'b1;
        repeat (6 * SC) @(posedge clk_i);
        run <= 1'b0;
        repeat (4) @(posedge clk_i);
        arm_c = 1'b0;
        chk(ncap - n, ok);
        p = raw * $signed(ctrl[10] ? vfac : fac);
        if (ok)
            last = p[47:16] + (ctrl[11] ? vofs : ofs);
        chk(result_o, last);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd & 32'h3, 32'h0);
    end
endtask
// arm a stop, run eight ticks, check stop and frozen position, then end the move
task stop_run(input [31:0] ctrl, input [31:0] t, input [31:0] p);
    begin
        apb(1'b1, 12'h010, t);
        apb(1'b1, 12'h000, ctrl);
        run <= 1'b1;
        repeat (8 * SC) @(posedge clk_i);
        chk(axis_stop_o, 32'h1);
        chk(pos, p);
        run <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(axis_stop_o, 32'h0);
    end
endtask
task t_reset;
    begin
        for (i = 0; i < 6; i = i + 1) begin
            apb(1'b0, {i[9:0], 2'h0}, 32'h0);
            chk(rd, i == 0 ? 32'h20 : i == 2 ? 32'h10000 : 32'h0);
        end
        apb(1'b0, 12'h01C, 32'h0);
        chk(err, 32'h1);
        apb(1'b1, 12'h000, 32'hFFFFE000);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
    end
endtask
task t_capture;
    begin
        cap_run(32'h21, 32'h8, 1'b1);
        for (i = 0; i < 3; i = i + 1)
            cap_run(32'h1 | (i << 2) | (((i + 1) % 3) << 5) | ((i == 2) << 4), i == 2 ? 32'h1EC : 32'hC, 1'b1);
        cap_run(32'h21, 32'h7FFF, 1'b0);
        cap_run(32'h20, 32'h0, 1'b0);
    end
endtask
task t_scale;
    begin
        fac = 32'h20000;
        ofs = 32'hFFFFFFF9;
        apb(1'b1, 12'h008, fac);
        apb(1'b1, 12'h00C, ofs);
        cap_run(32'h21, 32'h4, 1'b1);
        vfac <= 32'h8000;
        vofs <= 32'h5;
        cap_run(32'hC21, 32'h10, 1'b1);
        glitch <= 1'b1;
        cap_run(32'h25, 32'h10000000, 1'b0);
        glitch <= 1'b0;
    end
endtask
task t_stop;
    begin
        stop_run(32'h22, 32'hC, 32'h14);
        stop_run(32'hA2, 32'hA, 32'h8);
        vthr <= 32'h1E8;
        stop_run(32'h1302, 32'h0, 32'h14);
    end
endtask
// main sequence
initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_capture;
    t_scale;
    t_stop;
    end_sim;
end
// watchdog well beyond the expected run of under two thousand cycles
initial begin
    repeat (30000) @(posedge clk_i);
    bad_count = bad_count + 1;
    end_sim;
end
endmodule // threshold_capture_and_stop_monitor_tb_top
bind tcsm_monitor tcsm_checker #(.WIDTH(WIDTH), .SAMPLE_CYC(SAMPLE_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .move_active_i(move_active_i), .result_o(result_o),
    .cap_done_o(cap_done_o), .axis_stop_o(axis_stop_o), .sample_tick_o(sample_tick_o));
